// *** logic/lsr_top.sv ***
/*
 * lsr_top: read side of the status and register bank. Answers bit
 * reads of live and latched status and word reads of the input
 * registers and their holding mirror, one response byte per cycle.
 * Assumes: contact pins are asynchronous and read high when open;
 * reg_values, latch_clear and the request port are on clk; framing
 * and checksums are handled outside.
 */

module lsr_top #(
  parameter int NUM_REGS = 16,
  parameter int IDX_W    = 4
) (
  input  wire logic                     clk,          // 10 MHz clock
  input  wire logic                     rstn,         // sync reset
  input  wire logic [12:0]              contact_pins, // 1 = open
  input  wire logic [NUM_REGS-1:0][15:0] reg_values,  // register data
  input  wire logic                     latch_clear,  // clear latches
  input  wire logic                     req_valid,    // request strobe
  input  wire lsr_pkg::lsr_req_s        req,          // request fields
  output logic                          req_ready,    // idle, may take
  output lsr_pkg::lsr_rsp_s             rsp,          // response byte
  output logic [12:0]                   latched_status // sticky bits
);

  logic [12:0]         live_status;
  lsr_pkg::lsr_state_e state;
  logic [16:0]         cur_addr;
  logic [15:0]         remain;
  logic                lo_next;
  logic [7:0]          err_code;
  logic [7:0]          bit_byte;
  logic [15:0]         cur_word;
  logic [16:0]         req_end;
  logic                take;
  logic                func_ok;
  logic                addr_ok;
  logic                is_bits;

  // pins cross into clk before anything reads them
  lsr_sync #(
    .WIDTH (13)
  ) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    (contact_pins),
    .q    (live_status)
  );

  lsr_latch_bank #(
    .WIDTH (13)
  ) u_latch (
    .clk     (clk),
    .rstn    (rstn),
    .live    (live_status),
    .clear   (latch_clear),
    .latched (latched_status)
  );

  // bit at a discrete offset; unmapped offsets inside the span read 0
  function automatic logic disc_bit(
    input logic [16:0] a,
    input logic [12:0] live,
    input logic [12:0] lat
  );
    logic [16:0] d;
    disc_bit = 1'b0;
    d        = 17'h00000;
    if (a >= lsr_pkg::LIVE_FIRST && a <= lsr_pkg::LIVE_LAST) begin
      d        = a - lsr_pkg::LIVE_FIRST;
      disc_bit = live[d[3:0]];
    end else if (a >= lsr_pkg::LATCH_FIRST &&
                 a <= lsr_pkg::LATCH_LAST) begin
      d        = a - lsr_pkg::LATCH_FIRST;
      disc_bit = lat[d[3:0]];
    end
  endfunction

  assign take    = req_valid && req_ready;
  assign req_end = {1'b0, req.start} + {1'b0, req.qty};
  assign is_bits = (req.func == lsr_pkg::FC_READ_DISC);

  // both word read codes address the same array, so no copy can drift
  assign func_ok = is_bits ||
                   (req.func == lsr_pkg::FC_READ_HOLD) ||
                   (req.func == lsr_pkg::FC_READ_INPUT);

  always_comb begin
    addr_ok = 1'b0;
    if (is_bits) begin
      addr_ok = (req.qty != 16'h0000) &&
                (req.qty <= lsr_pkg::MAX_BIT_QTY) &&
                (req_end <= lsr_pkg::DISC_SPAN_END);
    end else begin
      addr_ok = (req.qty != 16'h0000) &&
                (req.qty <= lsr_pkg::MAX_REG_QTY) &&
                (req_end <= 17'(NUM_REGS));
    end
  end

  // up to eight bits packed per byte, lowest offset in bit 0
  always_comb begin
    bit_byte = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (16'(i) < remain) begin
        bit_byte[i] = disc_bit(cur_addr + 17'(i), live_status,
                               latched_status);
      end
    end
  end

  // the master has no path that writes this array
  assign cur_word = reg_values[cur_addr[IDX_W-1:0]];

  // sequencing of one answer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state    <= lsr_pkg::ST_IDLE;
      cur_addr <= 17'h00000;
      remain   <= 16'h0000;
      lo_next  <= 1'b0;
      err_code <= 8'h00;
    end else begin
      case (state)
        lsr_pkg::ST_IDLE: begin
          if (take) begin
            cur_addr <= {1'b0, req.start};
            remain   <= req.qty;
            lo_next  <= 1'b0;
            if (!func_ok) begin
              err_code <= lsr_pkg::EXC_ILLEGAL_FUNC;
              state    <= lsr_pkg::ST_ERR;
            end else if (!addr_ok) begin
              err_code <= lsr_pkg::EXC_ILLEGAL_ADDR;
              state    <= lsr_pkg::ST_ERR;
            end else if (is_bits) begin
              state <= lsr_pkg::ST_BITS;
            end else begin
              state <= lsr_pkg::ST_WORDS;
            end
          end
        end
        lsr_pkg::ST_BITS: begin
          cur_addr <= cur_addr + 17'(lsr_pkg::BITS_PER_BYTE);
          if (remain <= lsr_pkg::BITS_PER_BYTE) begin
            remain <= 16'h0000;
            state  <= lsr_pkg::ST_IDLE;
          end else begin
            remain <= remain - lsr_pkg::BITS_PER_BYTE;
          end
        end
        lsr_pkg::ST_WORDS: begin
          lo_next <= !lo_next;
          if (lo_next) begin
            // step to the next offset only after the low byte
            cur_addr <= cur_addr + 17'h00001;
            remain   <= remain - 16'h0001;
            if (remain == 16'h0001) begin
              state <= lsr_pkg::ST_IDLE;
            end
          end
        end
        lsr_pkg::ST_ERR: begin
          state <= lsr_pkg::ST_IDLE;
        end
        default: begin
          state <= lsr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // response byte stream, registered
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rsp <= '0;
    end else begin
      rsp <= '0;
      case (state)
        lsr_pkg::ST_BITS: begin
          rsp.valid <= 1'b1;
          rsp.data  <= bit_byte;
          rsp.last  <= (remain <= lsr_pkg::BITS_PER_BYTE);
        end
        lsr_pkg::ST_WORDS: begin
          rsp.valid <= 1'b1;
          // high byte goes out before the low byte
          rsp.data  <= lo_next ? cur_word[7:0]
                               : cur_word[15:8];
          rsp.last  <= lo_next && (remain == 16'h0001);
        end
        lsr_pkg::ST_ERR: begin
          rsp.valid <= 1'b1;
          rsp.data  <= err_code;
          rsp.last  <= 1'b1;
          rsp.error <= 1'b1;
        end
        default: begin
          rsp <= '0;
        end
      endcase
    end
  end

  // ready drops on the taking edge and returns with the last byte
  always_ff @(posedge clk) begin
    if (!rstn) begin
      req_ready <= 1'b1;
    end else if (take) begin
      req_ready <= 1'b0;
    end else if (state == lsr_pkg::ST_ERR) begin
      req_ready <= 1'b1;
    end else if (state == lsr_pkg::ST_BITS &&
                 remain <= lsr_pkg::BITS_PER_BYTE) begin
      req_ready <= 1'b1;
    end else if (state == lsr_pkg::ST_WORDS && lo_next &&
                 remain == 16'h0001) begin
      req_ready <= 1'b1;
    end
  end

endmodule

// *** logic/lsr_pkg.sv ***
/*
 * lsr_pkg: constants and types shared by the latched status and
 * register read block.
 * Assumes: included before any design file that names lsr_pkg.
 */
package lsr_pkg;

  // function codes that the read side answers
  localparam logic [7:0] FC_READ_DISC  = 8'h02;
  localparam logic [7:0] FC_READ_HOLD  = 8'h03;
  localparam logic [7:0] FC_READ_INPUT = 8'h04;

  // exception codes, sent as one byte with the error flag
  localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;

  localparam int NUM_STATUS = 13;

  // discrete input offsets
  localparam logic [16:0] LIVE_FIRST     = 17'h00011;
  localparam logic [16:0] LIVE_LAST      = 17'h0001D;
  localparam logic [16:0] LATCH_FIRST    = 17'h00021;
  localparam logic [16:0] LATCH_LAST     = 17'h0002D;
  localparam logic [16:0] DISC_SPAN_END  = 17'h0002E;

  // latched discrete inputs, one bit each
  localparam logic [15:0] OFF_MAIN_VALVE_FEEDBACK_LATCHED    = 16'h0021;
  localparam logic [15:0] OFF_PILOT_VALVE_FEEDBACK_LATCHED   = 16'h0022;
  localparam logic [15:0] OFF_HIGH_PRESSURE_CONTACT_LATCHED  = 16'h0023;
  localparam logic [15:0] OFF_CLOSURE_PROOF_CONTACT_LATCHED  = 16'h0024;
  localparam logic [15:0] OFF_EMERGENCY_STOP_CONTACT_LATCHED = 16'h0025;
  localparam logic [15:0] OFF_START_CONTACT_LATCHED          = 16'h0026;
  localparam logic [15:0] OFF_LOW_PRESSURE_CONTACT_LATCHED   = 16'h0027;
  localparam logic [15:0] OFF_FLAME_PRESENT_LATCHED          = 16'h0028;
  localparam logic [15:0] OFF_FLAME_SELFTEST_FAILED_LATCHED  = 16'h0029;
  localparam logic [15:0] OFF_UNIT_FAULT_LATCHED             = 16'h002A;
  localparam logic [15:0] OFF_SUPPLY_OUT_OF_RANGE_LATCHED    = 16'h002B;
  localparam logic [15:0] OFF_OVERTEMPERATURE_ALARM_LATCHED  = 16'h002C;
  localparam logic [15:0] OFF_LOOP_CURRENT_ALARM_LATCHED     = 16'h002D;

  // quantity limits per request
  localparam logic [15:0] MAX_REG_QTY = 16'h007D;
  localparam logic [15:0] MAX_BIT_QTY = 16'h07D0;
  localparam logic [15:0] BITS_PER_BYTE = 16'h0008;

  // values after reset
  localparam logic [12:0] LATCH_RESET  = 13'h0000;
  localparam logic [12:0] SYNC_RESET   = 13'h0000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BITS,
    ST_WORDS,
    ST_ERR
  } lsr_state_e;

  typedef struct packed {
    logic [7:0]  func;   // function code
    logic [15:0] start;  // first offset
    logic [15:0] qty;    // number of bits or registers
  } lsr_req_s;

  typedef struct packed {
    logic       valid;   // one byte this cycle
    logic [7:0] data;    // data byte or exception code
    logic       last;    // final byte of the answer
    logic       error;   // data holds an exception code
  } lsr_rsp_s;

endpackage

// *** logic/lsr_sync.sv ***
/*
 * lsr_sync: two-stage synchroniser for a vector of pin levels.
 * Assumes: inputs are asynchronous levels; clk is the block clock.
 */
module lsr_sync #(
  parameter int WIDTH = 13
) (
  input  wire logic             clk,   // block clock
  input  wire logic             rstn,  // sync reset, active low
  input  wire logic [WIDTH-1:0] d,     // asynchronous levels
  output logic      [WIDTH-1:0] q      // synchronised levels
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta <= WIDTH'(lsr_pkg::SYNC_RESET);
      q    <= WIDTH'(lsr_pkg::SYNC_RESET);
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// *** logic/lsr_latch_bank.sv ***
/*
 * lsr_latch_bank: sticky copies of live status bits.
 * Assumes: live and clear come from logic on the same clock.
 */
module lsr_latch_bank #(
  parameter int WIDTH = 13
) (
  input  wire logic             clk,     // block clock
  input  wire logic             rstn,    // sync reset, active low
  input  wire logic [WIDTH-1:0] live,    // live status bits
  input  wire logic             clear,   // reload latched bits from live
  output logic      [WIDTH-1:0] latched  // sticky copies
);

  // a bit that is set in the clearing cycle stays set
  always_ff @(posedge clk) begin
    if (!rstn) begin
      latched <= WIDTH'(lsr_pkg::LATCH_RESET);
    end else if (clear) begin
      latched <= live;
    end else begin
      latched <= latched | live;
    end
  end

endmodule

// *** verif/lsr_asserts.sv ***
/* lsr_asserts: port checks of lsr_top.
   Assumes: bound to lsr_top from the bench top file. */
module lsr_asserts #(
  parameter int NUM_REGS = 16,
  parameter int IDX_W    = 4
) (
  input wire logic                      clk,           // clock
  input wire logic                      rstn,          // reset
  input wire logic [12:0]               contact_pins,  // pins
  input wire logic [NUM_REGS-1:0][15:0] reg_values,    // data
  input wire logic                      latch_clear,   // clear
  input wire logic                      req_valid,     // strobe
  input wire lsr_pkg::lsr_req_s         req,           // request
  input wire logic                      req_ready,     // idle
  input wire lsr_pkg::lsr_rsp_s         rsp,           // byte
  input wire logic [12:0]               latched_status // sticky
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence take_s;
    req_valid && req_ready;
  endsequence
  sequence one_s;
    take_s ##0 (req.func == 8'h03 || req.func == 8'h04)
      && req.qty == 16'h0001 && req.start < NUM_REGS;
  endsequence
  // two bytes back to back, the second one closing the answer
  sequence pair_s;
    rsp.valid && !rsp.last ##1 rsp.valid && rsp.last;
  endsequence
  ready_drop_a: assert property (take_s |=> !req_ready)
    else $error("ready high after a take");
  first_byte_a: assert property (
    take_s |=> !rsp.valid ##1 rsp.valid)
    else $error("first byte late or early");
  end_ready_a: assert property (
    rsp.valid && rsp.last |-> req_ready)
    else $error("ready low at last byte");
  burst_run_a: assert property (
    rsp.valid && !rsp.last |=> rsp.valid)
    else $error("gap inside an answer");
  one_reg_a: assert property (one_s |=> ##1 pair_s)
    else $error("one register not two bytes");
  write_refused_a: assert property (
    take_s ##0 req.func == 8'h06
    |=> ##1 rsp.valid && rsp.error && rsp.data == 8'h01)
    else $error("write not refused");
  latch_hold_a: assert property (
    !latch_clear |=>
    (latched_status & $past(latched_status)) == $past(latched_status))
    else $error("sticky bit dropped");
  pin_latch_a: assert property (
    contact_pins[12] [*3] |=> latched_status[12])
    else $error("open contact not latched");
  clear_latch_a: assert property (
    (contact_pins == 13'h0000) [*3] ##0 latch_clear
    |=> latched_status == 13'h0000)
    else $error("clear ignored");
endmodule

// *** verif/lsr_master.sv ***
/* lsr_master: behavioural serial-bus master issuing read requests.
   Assumes: one clock; drives on falling edges. */
module lsr_master (
  input  wire logic              clk,       // clock
  input  wire logic              req_ready, // device idle
  input  wire lsr_pkg::lsr_rsp_s rsp,       // answer byte
  output logic                   req_valid, // strobe
  output lsr_pkg::lsr_req_s      req        // fields
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  logic       got_err;
  logic       hung;
  initial begin
    req_valid = 1'b0;
    req = '0;
    hung = 1'b0;
  end
  task automatic xfer(input logic [7:0] f, input logic [15:0] s, q,
                      input int gap);
    int n;
    got = {};
    got_err = 1'b0;
    repeat (gap) @(negedge clk);
    for (n = 0; n < 50 && req_ready !== 1'b1; n++) @(negedge clk);
    // a device that never comes ready counts as a hang
    if (req_ready !== 1'b1) begin
      hung = 1'b1;
      return;
    end
    req_valid = 1'b1;
    req = '{func: f, start: s, qty: q};
    @(negedge clk);
    req_valid = 1'b0;
    req = ~req; // released fields do not keep their value
    for (n = 0; n < 400; n++) begin
      if (rsp.valid === 1'b1) begin
        got.push_back(rsp.data);
        got_err = rsp.error;
        if (rsp.last === 1'b1) break;
      end
      @(negedge clk);
    end
    if (n == 400) hung = 1'b1;
  endtask
endmodule

// *** verif/tb_top.sv ***
/* tb_top: self-checking bench for lsr_top with a master model.
   Assumes: package and design files compiled first. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic [12:0]       pins = '0;
  logic [15:0][15:0] regs;
  logic              clr = 1'b0;
  logic              rv;
  logic              rr;
  lsr_pkg::lsr_req_s rq;
  lsr_pkg::lsr_rsp_s rs;
  logic [12:0]       lat;
  int                err_count = 0;
  int                n_compared = 0;
  always #50 clk = ~clk;
  lsr_top dut (.clk(clk), .rstn(rstn), .contact_pins(pins),
    .reg_values(regs), .latch_clear(clr), .req_valid(rv), .req(rq),
    .req_ready(rr), .rsp(rs), .latched_status(lat));
  lsr_master m (.clk(clk), .req_ready(rr), .rsp(rs), .req_valid(rv),
    .req(rq));
  function automatic logic [15:0] rval(int k);
    return {4'(k), 4'hC, ~4'(k), 4'h3};
  endfunction
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic rd(logic [7:0] f, logic [15:0] s, q, int gap);
    m.xfer(f, s, q, gap);
    if (m.hung) begin
      err_count++;
      close_out;
    end
  endtask
  task automatic words(logic [7:0] f, int s, int n, int gap);
    logic [15:0] w;
    logic [7:0]  e;
    rd(f, 16'(s), 16'(n), gap);
    chk("byte count", 16'(2 * n), 16'(m.got.size()));
    for (int i = 0; i < 2 * n; i++) begin
      w = rval(s + i / 2);
      e = i[0] ? w[7:0] : w[15:8];
      chk("word byte", {8'h00, e}, {8'h00, m.got[i]});
    end
  endtask
  task automatic t_words;
    words(lsr_pkg::FC_READ_INPUT, 3, 2, 0);
    words(lsr_pkg::FC_READ_HOLD, 3, 2, 3);
    words(lsr_pkg::FC_READ_HOLD, 15, 1, 0);
    words(lsr_pkg::FC_READ_INPUT, 0, 16, 0);
    $display("t_words done");
  endtask
  task automatic t_refuse;
    logic [7:0] wr[2] = '{8'h06, 8'h10};
    foreach (wr[i]) begin
      rd(wr[i], 16'h0003, 16'h0001, 0);
      chk("write answer", 16'h0101, {7'h0, m.got_err, m.got[0]});
    end
    // range past the last register is refused with the address code
    rd(lsr_pkg::FC_READ_INPUT, 16'h000F, 16'h0002, 0);
    chk("range answer", 16'h0102, {7'h0, m.got_err, m.got[0]});
    words(lsr_pkg::FC_READ_INPUT, 3, 1, 0);
    $display("t_refuse done");
  endtask
  task automatic t_latch;
    pins = 13'h0010;
    repeat (4) @(negedge clk);
    pins = 13'h1000;
    repeat (4) @(negedge clk);
    rd(lsr_pkg::FC_READ_DISC, 16'h0011, 16'h000D, 0);
    chk("bit bytes", 16'h0002, 16'(m.got.size()));
    chk("live read", 16'h1000, {m.got[1], m.got[0]});
    rd(lsr_pkg::FC_READ_DISC, 16'h0021, 16'h000D, 0);
    chk("latched read", 16'h1010, {m.got[1], m.got[0]});
    pins = 13'h0000;
    repeat (4) @(negedge clk);
    chk("sticky bits", 16'h1010, {3'h0, lat});
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    @(negedge clk);
    chk("cleared bits", 16'h0000, {3'h0, lat});
    $display("t_latch done");
  endtask
  initial begin
    for (int k = 0; k < 16; k++) regs[k] = rval(k);
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk("idle ready", 16'h0001, {15'h0, rr});
    chk("idle latched", 16'h0000, {3'h0, lat});
    $display("t_reset done");
    t_words;
    t_refuse;
    t_latch;
    close_out;
  end
endmodule
bind lsr_top lsr_asserts #(.NUM_REGS(NUM_REGS), .IDX_W(IDX_W)) chk_i (
  .clk(clk), .rstn(rstn), .contact_pins(contact_pins),
  .reg_values(reg_values), .latch_clear(latch_clear),
  .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp(rsp),
  .latched_status(latched_status));
